// ===== logic/ccc_pkg.sv
// Shared constants for the cascade chain control block.
package ccc_pkg;
  // Device-select value that enables every device in the string
  localparam logic [15:0] SEL_ALL = 16'hFFFF;
  // Chain-position reset value, only loaded by the reset pin
  localparam logic [15:0] CP_RESET = 16'h0000;
  // Device-select reset value
  localparam logic [15:0] SEL_RESET = 16'hFFFF;
  // Position of the translation select field in a control word
  localparam int XLAT_LSB = 9;
  localparam int XLAT_MSB = 10;
  // Translation select codes
  localparam logic [1:0] XLAT_ON = 2'h1;
  localparam logic [1:0] XLAT_OFF = 2'h2;
  // Pin synchroniser depth and idle level of the pin group
  localparam int SYNC_STAGES = 3;
  localparam logic [3:0] PIN_IDLE = 4'hF;
  // Bit slots of the synchronised pin group
  localparam int PIN_STROBE = 0;
  localparam int PIN_CHAIN = 1;
  localparam int PIN_MATCH = 2;
  localparam int PIN_FULL = 3;
endpackage

// ===== logic/ccc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
module ccc_pin_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] IDLE = '1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinOut
);
  // Stage flops; stage one feeds only stage two
  logic [W-1:0] s1_r, s2_r, s3_r, out_r;
  logic [W-1:0] out_nxt;

  // A bit moves only once stages two and three agree
  always_comb begin
    out_nxt = (s2_r & ~(s2_r ^ s3_r)) | (out_r & (s2_r ^ s3_r));
  end

  // Register the chain
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r <= IDLE;
      s2_r <= IDLE;
      s3_r <= IDLE;
      out_r <= IDLE;
    end else begin
      s1_r <= pinIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign pinOut = out_r;
endmodule

// ===== logic/ccc_bit_xlat.sv
// Byte-wise bit-order translation between the two address formats.
`timescale 1ns/1ps
module ccc_bit_xlat (
  input wire logic enable,
  input wire logic [15:0] dataIn,
  output logic [15:0] dataOut
);
  // Reverse bits inside each byte: n to 7-n, and n to 23-n
  always_comb begin
    dataOut = dataIn;
    if (enable) begin
      for (int n = 0; n < 8; n++) begin
        dataOut[7 - n] = dataIn[n];
        dataOut[15 - n] = dataIn[8 + n];
      end
    end
  end
endmodule

// ===== logic/ccc_chain_ctrl.sv
// Cascade chain control: match and full daisy chains, lock, translation, position.
//
// Summary of operation
// - Highest priority: match in high, match out low
// - Standard locked: only highest priority device responds
// - Enhanced locked: writes accepted, reads highest only
// - Chain enable latched on fall, registered rise
// - First low cycle: all selected devices write
// - Lock persists while enable sampled low
// - No match, standard: nobody responds until unlock
// - Next free ops steered by full chain
// - Standard unlocking cycle acts only on highest match
// - Enhanced: writes accepted even while locked
// - Match ops highest only; free ops free target
// - Move comparand to first free, mark valid
// - Last full out reports whole string full
// - Translation reverses bits inside each byte
// - Control bits 10 and 9 select translation
// - Control reset returns to untranslated data
// - Position write and set-full only free target
// - Set-full drives full out low when empty
// - Control reset keeps chain position value
`timescale 1ns/1ps
module ccc_chain_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic cycle_strobe_n,
  input wire logic chain_enable_n,
  input wire logic match_in_n,
  input wire logic full_in_n,
  input wire logic cycWrite,
  input wire logic cycCommand,
  input wire logic opHighMatch,
  input wire logic opNextFree,
  input wire logic opSetFull,
  input wire logic opMoveFreeValid,
  input wire logic opPositionWrite,
  input wire logic opSelectWrite,
  input wire logic opControlWrite,
  input wire logic opControlReset,
  input wire logic [15:0] cycData,
  input wire logic enhancedMode,
  input wire logic localMatch,
  input wire logic localFull,
  output logic match_out_n,
  output logic full_out_n,
  output logic chainLocked,
  output logic readEnable,
  output logic writeExec,
  output logic moveFreeValid,
  output logic [15:0] busData,
  output logic translateOn,
  output logic [15:0] chainPosition,
  output logic [15:0] deviceSelect
);
  import ccc_pkg::*;

  // Synchronised pins
  logic [3:0] pinSync;
  logic strobeN, ecN, miN, fiN;
  // Previous strobe level for edge detection
  logic strobePrev_r, strobePrev_nxt;
  logic strobeFall, strobeRise;
  // Latched chain enable and lock state
  logic ecLatch_r, ecLatch_nxt;
  logic locked_r, locked_nxt;
  // Daisy chain flags
  logic matchOutN_r, matchOutN_nxt;
  logic fullOutN_r, fullOutN_nxt;
  logic setFull_r, setFull_nxt;
  // Cycle results
  logic readEn_r, readEn_nxt;
  logic writeExec_r, writeExec_nxt;
  logic moveFree_r, moveFree_nxt;
  logic [15:0] busData_r, busData_nxt;
  logic xlat_r, xlat_nxt;
  logic [15:0] pos_r, pos_nxt;
  logic [15:0] devSel_r, devSel_nxt;
  // Decode terms
  logic highest, freeTarget, selAll, selOwn, selected, wrOk, rdOk, exec;
  logic [15:0] xlatData;
  logic [1:0] xlatSel;

  // The strobe, chain enable, match in and full in pins pass the agreement synchroniser; cycle attributes and data do not
  ccc_pin_sync #(
    .W(4),
    .IDLE(PIN_IDLE)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .pinIn({full_in_n, match_in_n, chain_enable_n, cycle_strobe_n}),
    .pinOut(pinSync)
  );

  assign strobeN = pinSync[PIN_STROBE];
  assign ecN = pinSync[PIN_CHAIN];
  assign miN = pinSync[PIN_MATCH];
  assign fiN = pinSync[PIN_FULL];

  // Translator sits on the incoming write data
  ccc_bit_xlat u_xlat (
    .enable(xlat_r),
    .dataIn(cycData),
    .dataOut(xlatData)
  );

  // Position decode shared by read and write paths
  function automatic logic ownSelect(input logic [15:0] sel, input logic [15:0] pos);
    ownSelect = (sel == pos);
  endfunction

  // Decode of who may respond in the current cycle
  always_comb begin
    strobeFall = strobePrev_r & ~strobeN;
    strobeRise = ~strobePrev_r & strobeN;
    highest = miN & ~matchOutN_r;
    freeTarget = ~fiN & fullOutN_r;
    selAll = (devSel_r == SEL_ALL);
    selOwn = ownSelect(devSel_r, pos_r);
    selected = selAll | selOwn;
    xlatSel = cycData[XLAT_MSB:XLAT_LSB];
    // Unlocked: device select alone decides; this is the first low cycle too
    if (!locked_r) begin
      wrOk = selected;
    end else if (enhancedMode) begin
      wrOk = selected;
    end else begin
      wrOk = highest;
    end
    // Locked reads are only for the match device; unlocked reads need select equal to position
    if (locked_r) begin
      rdOk = highest;
    end else begin
      rdOk = selOwn;
    end
    // Target gating: match ops need the match device, free ops the free one
    if (opHighMatch) begin
      exec = wrOk & highest;
    end else if (opNextFree | opSetFull | opPositionWrite | opMoveFreeValid) begin
      exec = wrOk & freeTarget;
    end else begin
      exec = wrOk;
    end
  end

  // Next values for every piece of control state
  always_comb begin
    strobePrev_nxt = strobeN;
    ecLatch_nxt = ecLatch_r;
    locked_nxt = locked_r;
    matchOutN_nxt = ~(~miN | localMatch);
    fullOutN_nxt = ~(~fiN & (localFull | setFull_r));
    setFull_nxt = setFull_r;
    readEn_nxt = readEn_r;
    writeExec_nxt = 1'b0;
    moveFree_nxt = 1'b0;
    busData_nxt = busData_r;
    xlat_nxt = xlat_r;
    pos_nxt = pos_r;
    devSel_nxt = devSel_r;
    // Falling strobe: latch enable and run the cycle
    if (strobeFall) begin
      ecLatch_nxt = ecN;
      if (cycWrite) begin
        if (exec) begin
          writeExec_nxt = 1'b1;
          if (!cycCommand) begin
            busData_nxt = xlatData;
          end
          if (opSetFull) begin
            setFull_nxt = 1'b1;
          end
          if (opMoveFreeValid) begin
            moveFree_nxt = 1'b1;
          end
          if (opPositionWrite) begin
            pos_nxt = cycData;
          end
          if (opSelectWrite) begin
            devSel_nxt = cycData;
          end
          // Only the two defined codes change the translation state
          if (opControlWrite && xlatSel == XLAT_ON) begin
            xlat_nxt = 1'b1;
          end else if (opControlWrite && xlatSel == XLAT_OFF) begin
            xlat_nxt = 1'b0;
          end
          // Control reset: position survives; translation, set-full and device select return to defaults
          if (opControlReset) begin
            xlat_nxt = 1'b0;
            setFull_nxt = 1'b0;
            devSel_nxt = SEL_RESET;
            pos_nxt = pos_r;
          end
        end
      end else begin
        readEn_nxt = rdOk;
      end
    end
    // Rising strobe: latched enable governs the next cycle
    if (strobeRise) begin
      locked_nxt = ~ecLatch_r;
      readEn_nxt = 1'b0;
    end
  end

  // Register all state; reset pin gives a known start
  always_ff @(posedge clk) begin
    if (rst) begin
      strobePrev_r <= 1'b1;
      ecLatch_r <= 1'b1;
      locked_r <= 1'b0;
      matchOutN_r <= 1'b1;
      fullOutN_r <= 1'b1;
      setFull_r <= 1'b0;
      readEn_r <= 1'b0;
      writeExec_r <= 1'b0;
      moveFree_r <= 1'b0;
      busData_r <= 16'h0000;
      xlat_r <= 1'b0;
      pos_r <= CP_RESET;
      devSel_r <= SEL_RESET;
    end else begin
      strobePrev_r <= strobePrev_nxt;
      ecLatch_r <= ecLatch_nxt;
      locked_r <= locked_nxt;
      matchOutN_r <= matchOutN_nxt;
      fullOutN_r <= fullOutN_nxt;
      setFull_r <= setFull_nxt;
      readEn_r <= readEn_nxt;
      writeExec_r <= writeExec_nxt;
      moveFree_r <= moveFree_nxt;
      busData_r <= busData_nxt;
      xlat_r <= xlat_nxt;
      pos_r <= pos_nxt;
      devSel_r <= devSel_nxt;
    end
  end

  // Outputs straight from flops
  assign match_out_n = matchOutN_r;
  assign full_out_n = fullOutN_r;
  assign chainLocked = locked_r;
  assign readEnable = readEn_r;
  assign writeExec = writeExec_r;
  assign moveFreeValid = moveFree_r;
  assign busData = busData_r;
  assign translateOn = xlat_r;
  assign chainPosition = pos_r;
  assign deviceSelect = devSel_r;

  // Checks on the chain behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Plain write with no target restriction
  sequence plainWriteFall;
    strobeFall && cycWrite && !opHighMatch && !opNextFree && !opSetFull
      && !opPositionWrite && !opMoveFreeValid;
  endsequence

  sequence setFullTaken;
    // A control reset in the same write clears the flag again
    strobeFall && cycWrite && opSetFull && exec && freeTarget && !opControlReset;
  endsequence

  a_read_highest_only: assert property (
    strobeFall && !cycWrite && locked_r && !(miN && !matchOutN_r) |=> !readEn_r)
    else $error("locked read granted to a non-highest device");
  a_std_lock_write: assert property (
    strobeFall && cycWrite && locked_r && !enhancedMode && !highest |=> !writeExec_r)
    else $error("standard locked write executed off the highest device");
  a_enh_write_ok: assert property (
    plainWriteFall and (locked_r && enhancedMode && selected) |=> writeExec_r)
    else $error("enhanced locked write was refused");
  a_first_low_all: assert property (
    plainWriteFall and (!locked_r && selAll) |=> writeExec_r)
    else $error("unlocked select-all write was refused");
  a_lock_follows_ec: assert property (
    strobeRise |=> locked_r == !$past(ecLatch_r))
    else $error("lock state did not follow latched enable");
  a_lock_holds: assert property (
    !strobeRise && !rst |=> $stable(locked_r))
    else $error("lock changed away from a rising strobe");
  a_free_target_only: assert property (
    strobeFall && cycWrite && opMoveFreeValid && !freeTarget |=> !moveFree_r)
    else $error("free move executed off the free target");
  a_set_full_low: assert property (
    setFullTaken ##1 (!fiN)[*2] |-> !fullOutN_r)
    else $error("set-full did not pull full out low");
  a_reset_keeps_pos: assert property (
    strobeFall && cycWrite && opControlReset && exec && !opPositionWrite
      |=> $stable(pos_r) && !xlat_r)
    else $error("control reset disturbed position or translation");
  a_match_ripple: assert property (
    (!miN || localMatch) ##1 (!miN || localMatch) |-> !matchOutN_r)
    else $error("match out not low on match in or local hit");
endmodule

// ===== test/ccc_neighbour_model.sv
// Upstream neighbour device that feeds the match-in and full-in pins.
`timescale 1ns/1ps
module ccc_neighbour_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic upHit,
  input wire logic upFull,
  output logic match_in_n,
  output logic full_in_n
);
  // Outputs follow the neighbour's own state one clock later, like a real flag
  always_ff @(posedge clk) begin
    if (rst) begin
      // A device in reset shows idle flags
      match_in_n <= 1'b1;
      full_in_n <= 1'b1;
    end else begin
      match_in_n <= ~upHit;
      full_in_n <= ~upFull;
    end
  end
endmodule

// ===== test/ccc_chain_ctrl_tb.sv
// Self-checking bench for the cascade chain control block.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
  $display("ERROR %0t mismatch got %h exp %h", $time, a, b); end end
module ccc_chain_ctrl_tb;
  import ccc_pkg::*;
  localparam int HIT = 0, FREE = 1, SF = 2, MV = 3, PW = 4, SW = 5, CW = 6, CR = 7;
  logic clk = 1'b0, rst = 1'b1, strobeN = 1'b1, ecN = 1'b1;
  logic cycWrite = 1'b0, cycCommand = 1'b0, enhancedMode = 1'b0;
  logic localMatch = 1'b0, localFull = 1'b0, upHit = 1'b0, upFull = 1'b1;
  logic [7:0] ops = 8'h00; // Op class strobes, one bit per class
  logic [15:0] cycData = 16'h0000, busData, chainPosition, deviceSelect, d;
  logic matchInN, fullInN, match_out_n, full_out_n, chainLocked;
  logic readEnable, writeExec, moveFreeValid, translateOn;
  logic ex, mv, rd; // What the last cycle produced
  int seed = 7246, failures = 0, checked = 0, cycles = 0;
  always #25 clk = ~clk;
  ccc_neighbour_model i_nb (.clk(clk), .rst(rst), .upHit(upHit), .upFull(upFull),
    .match_in_n(matchInN), .full_in_n(fullInN));
  ccc_chain_ctrl i_dut (.clk(clk), .rst(rst), .cycle_strobe_n(strobeN),
    .chain_enable_n(ecN), .match_in_n(matchInN), .full_in_n(fullInN),
    .cycWrite(cycWrite), .cycCommand(cycCommand), .opHighMatch(ops[HIT]),
    .opNextFree(ops[FREE]), .opSetFull(ops[SF]), .opMoveFreeValid(ops[MV]),
    .opPositionWrite(ops[PW]), .opSelectWrite(ops[SW]), .opControlWrite(ops[CW]),
    .opControlReset(ops[CR]), .cycData(cycData), .enhancedMode(enhancedMode),
    .localMatch(localMatch), .localFull(localFull), .match_out_n(match_out_n),
    .full_out_n(full_out_n), .chainLocked(chainLocked), .readEnable(readEnable),
    .writeExec(writeExec), .moveFreeValid(moveFreeValid), .busData(busData),
    .translateOn(translateOn), .chainPosition(chainPosition),
    .deviceSelect(deviceSelect));
  // Expected byte-wise bit reversal, built from the mapping directly
  function automatic logic [15:0] xlat(input logic [15:0] v);
    logic [15:0] r;
    for (int n = 0; n < 8; n++) r[7-n] = v[n];
    for (int n = 8; n < 16; n++) r[23-n] = v[n];
    return r;
  endfunction
  // One strobe cycle; attributes held through both phases, 9 clk each
  task automatic cyc(input logic w, input logic cmd, input logic [7:0] op,
    input logic [15:0] v, input logic ec);
    @(posedge clk);
    cycWrite <= w;
    cycCommand <= cmd;
    ops <= op;
    cycData <= v;
    ecN <= ec;
    strobeN <= 1'b0;
    ex = 1'b0;
    mv = 1'b0;
    rd = 1'b0;
    repeat (8) begin
      @(posedge clk);
      #1;
      ex |= writeExec;
      mv |= moveFreeValid;
      rd |= readEnable;
    end
    @(posedge clk);
    strobeN <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
  endtask
  // Let pin changes cross the synchroniser
  task automatic settle();
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Hang guard, well above the roughly 620 clocks the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    settle();
    `CHK({chainPosition, deviceSelect, translateOn}, {CP_RESET, SEL_RESET, 1'b0})
    `CHK({full_out_n, match_out_n}, 2'b11)
    // Position load, set-full advance, then refusal once this device is taken
    cyc(1, 1, 8'h01 << PW, 16'h0005, 1);
    `CHK({ex, chainPosition}, {1'b1, 16'h0005})
    cyc(1, 1, 8'h01 << SF, 16'h0000, 1);
    `CHK(full_out_n, 1'b0)
    cyc(1, 1, 8'h01 << PW, 16'h0009, 1);
    `CHK({ex, chainPosition}, {1'b0, 16'h0005})
    cyc(1, 1, 8'h01 << MV, 16'h0000, 1);
    `CHK(mv, 1'b0)
    cyc(1, 1, 8'h01 << CW, 16'h0200, 1);
    cyc(1, 1, 8'h01 << CR, 16'h0000, 1);
    `CHK({chainPosition, full_out_n, translateOn}, {16'h0005, 2'b10})
    cyc(1, 1, 8'h01 << MV, 16'h0000, 1);
    `CHK({ex, mv}, 2'b11)
    // Unlocked read only with select equal to position
    cyc(1, 1, 8'h01 << SW, 16'h0005, 1);
    `CHK(deviceSelect, 16'h0005)
    cyc(0, 0, 8'h00, 16'h0000, 1);
    `CHK(rd, 1'b1)
    cyc(1, 1, 8'h01 << SW, SEL_ALL, 1);
    `CHK(deviceSelect, SEL_ALL)
    upFull <= 1'b0;
    settle();
    cyc(1, 1, 8'h01 << FREE, 16'h0000, 1);
    `CHK(ex, 1'b0)
    localFull <= 1'b1;
    settle();
    `CHK(full_out_n, 1'b1)
    upFull <= 1'b1;
    settle();
    `CHK(full_out_n, 1'b0)
    localFull <= 1'b0;
    // Translation on, random data, then off
    cyc(1, 1, 8'h01 << CW, 16'h0200, 1);
    `CHK(translateOn, 1'b1)
    for (int i = 0; i < 6; i++) begin
      d = 16'($random(seed));
      cyc(1, 0, 8'h00, d, 1);
      `CHK(busData, xlat(d))
    end
    cyc(1, 1, 8'h01 << CW, 16'h0400, 1);
    d = 16'($random(seed));
    cyc(1, 0, 8'h00, d, 1);
    `CHK({translateOn, busData}, {1'b0, d})
    // Match ripple from local hit and from upstream
    localMatch <= 1'b1;
    settle();
    `CHK(match_out_n, 1'b0)
    localMatch <= 1'b0;
    upHit <= 1'b1;
    settle();
    `CHK(match_out_n, 1'b0)
    upHit <= 1'b0;
    settle();
    // Standard lock: first low cycle runs for all, then only the highest
    cyc(1, 0, 8'h00, 16'h1234, 0);
    `CHK({ex, chainLocked}, 2'b11)
    cyc(1, 0, 8'h00, 16'h4321, 0);
    `CHK({ex, chainLocked}, 2'b01)
    cyc(0, 0, 8'h00, 16'h0000, 0);
    `CHK(rd, 1'b0)
    localMatch <= 1'b1;
    settle();
    cyc(0, 1, 8'h00, 16'h0000, 0);
    `CHK(rd, 1'b1)
    cyc(1, 0, 8'h01 << HIT, 16'h5555, 0);
    `CHK({ex, chainLocked}, 2'b11)
    upHit <= 1'b1;
    settle();
    cyc(0, 0, 8'h00, 16'h0000, 0);
    `CHK(rd, 1'b0)
    upHit <= 1'b0;
    localMatch <= 1'b0;
    enhancedMode <= 1'b1;
    settle();
    // Enhanced lock: plain writes pass, reads and match-targeted writes do not
    cyc(1, 0, 8'h00, 16'h0F0F, 0);
    `CHK(ex, 1'b1)
    cyc(0, 0, 8'h00, 16'h0000, 0);
    `CHK(rd, 1'b0)
    cyc(1, 0, 8'h01 << HIT, 16'h0F0F, 0);
    `CHK(ex, 1'b0)
    enhancedMode <= 1'b0;
    // Unlock no-op: still locked, no match, so nothing runs
    cyc(1, 0, 8'h00, 16'hAAAA, 1);
    `CHK({ex, chainLocked}, 2'b00)
    cyc(1, 0, 8'h00, 16'hBBBB, 1);
    `CHK(ex, 1'b1)
    wrap_up();
  end
endmodule
